//--- rtl/twssp_top.sv
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
// Function
// - eight-bit shift register, data in, out, clock
// - internal clock is master, external is slave
// - port works only with port select set
// - rate bits give 2, 4, 8 instruction cycles
// - busy write starts, cleared after eight bits
// - software busy clear stops master-mode shifting early; a slave frame keeps shifting on the external clock
// - enabled interrupt request on eight-bit completion
// - shift clock idles low when not shifting
// - master initiates; slave never starts alone
// - bit four enables output, five picks clock
// - normal: sample rising, shift falling
// - alternate phase shifts on rising edge
// - phase select in bit six, resets clear
module twssp_top
    import twssp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    input  wire logic        shift_clock_in,
    output logic             shift_clock_out,
    output logic             shift_clock_oe,
    output logic             shift_done_irq
);
    import twssp_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [1:0]    clock_rate;
    logic          serial_port_select;
    logic          busy;
    logic          irq_en;
    logic          cfg_out_en;
    logic          cfg_clk_int;
    logic          clock_phase_select;
    logic [7:0]    serial_shift_reg;
    logic          bus_req;
    logic          bus_wr;
    logic [3:0]    word_adr;
    logic [7:0]    read_byte;
    logic          go;
    logic          stop_req;
    logic          master_done;
    logic          slave_done;
    logic          start_tgl;
    logic          si_s1;
    logic          si_s2;
    logic          done_s1;
    logic          done_s2;
    logic          done_s3;
    twssp_mstate_t m_state;
    logic [7:0]    m_timer;
    logic [3:0]    m_cnt;
    logic          m_sample;
    logic          m_rise;
    logic          m_fall;
    logic          m_shift;
    logic          m_din;
    logic          link_clk;
    logic          s_sample;
    logic          s_din;
    logic [7:0]    s_sr;
    logic [3:0]    s_cnt;
    logic          s_seen;
    logic          s_done_tgl;
    logic          s_frame;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] half_period(input logic [1:0] rate);
        logic [7:0] h;
        h = HALF_RATE2;
        case (rate)
            2'b00:   h = HALF_RATE0;
            2'b01:   h = HALF_RATE1;
            default: h = HALF_RATE2;
        endcase
        return h;
    endfunction

    // ************************************************************
    // wishbone slave
    // ************************************************************
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign bus_wr   = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign word_adr = {wb_adr_i[3:2], 2'b00};

    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    always_comb begin
        read_byte = 8'h00;
        case (word_adr)
            ADDR_CONTROL: begin
                read_byte[CTRL_RATE_LOW]  = clock_rate[0];
                read_byte[CTRL_RATE_HIGH] = clock_rate[1];
                read_byte[CTRL_PORT_SEL]  = serial_port_select;
            end
            ADDR_STATUS: begin
                read_byte[STAT_BUSY]   = busy;
                read_byte[STAT_IRQ_EN] = irq_en;
            end
            ADDR_PORT_CFG: begin
                read_byte[CFG_OUT_EN]  = cfg_out_en;
                read_byte[CFG_CLK_INT] = cfg_clk_int;
                read_byte[CFG_PHASE]   = clock_phase_select;
            end
            ADDR_DATA: begin
                read_byte = serial_shift_reg;
            end
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= {24'h000000, read_byte};
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            clock_rate         <= RATE_RST;
            serial_port_select <= 1'b0;
        end else if (bus_wr && word_adr == ADDR_CONTROL) begin
            clock_rate         <= {wb_dat_i[CTRL_RATE_HIGH], wb_dat_i[CTRL_RATE_LOW]};
            serial_port_select <= wb_dat_i[CTRL_PORT_SEL];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_out_en         <= 1'b0;
            cfg_clk_int        <= 1'b0;
            clock_phase_select <= 1'b0;
        end else if (bus_wr && word_adr == ADDR_PORT_CFG) begin
            cfg_out_en         <= wb_dat_i[CFG_OUT_EN];
            cfg_clk_int        <= wb_dat_i[CFG_CLK_INT];
            clock_phase_select <= wb_dat_i[CFG_PHASE];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_en <= 1'b0;
        end else if (bus_wr && word_adr == ADDR_STATUS) begin
            irq_en <= wb_dat_i[STAT_IRQ_EN];
        end
    end

    // ************************************************************
    // busy flag and transfer start
    // ************************************************************
    // start only from idle with the port routed to the pins
    assign go = bus_wr && word_adr == ADDR_STATUS && wb_dat_i[STAT_BUSY]
                && !busy && serial_port_select;
    assign stop_req = bus_wr && word_adr == ADDR_STATUS && !wb_dat_i[STAT_BUSY];

    assign master_done = m_fall && m_cnt == LAST_BIT && busy;
    assign slave_done  = (done_s2 ^ done_s3) && busy && !cfg_clk_int;

    always_ff @(posedge mclk) begin
        if (reset) begin
            busy <= 1'b0;
        end else if (go) begin
            busy <= 1'b1;
        end else if (stop_req) begin
            busy <= 1'b0;
        end else if (master_done || slave_done) begin
            busy <= 1'b0;
        end
    end

    // slave frames are armed by a toggle, never started by the slave
    always_ff @(posedge mclk) begin
        if (reset) begin
            start_tgl <= 1'b0;
        end else if (go && !cfg_clk_int) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            shift_done_irq <= 1'b0;
        end else begin
            shift_done_irq <= irq_en & (master_done | slave_done);
        end
    end

    // ************************************************************
    // synchronisers into mclk
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            si_s1   <= 1'b0;
            si_s2   <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            si_s1   <= serial_in;
            si_s2   <= si_s1;
            done_s1 <= s_done_tgl;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end

    // ************************************************************
    // master clock generator
    // ************************************************************
    assign m_rise = m_state == M_LOW && m_timer == 8'h00 && busy;
    assign m_fall = m_state == M_HIGH && m_timer == 8'h00 && busy;

    always_ff @(posedge mclk) begin
        if (reset) begin
            m_state <= M_IDLE;
            m_timer <= 8'h00;
            m_cnt   <= 4'h0;
        end else begin
            case (m_state)
                M_IDLE: begin
                    if (go && cfg_clk_int) begin
                        m_state <= M_LOW;
                        m_timer <= half_period(clock_rate) - 8'h01;
                        m_cnt   <= 4'h0;
                    end
                end
                M_LOW: begin
                    if (!busy || stop_req) begin
                        m_state <= M_IDLE;
                    end else if (m_timer == 8'h00) begin
                        m_state <= M_HIGH;
                        m_timer <= half_period(clock_rate) - 8'h01;
                    end else begin
                        m_timer <= m_timer - 8'h01;
                    end
                end
                M_HIGH: begin
                    if (!busy || stop_req) begin
                        m_state <= M_IDLE;
                    end else if (m_timer == 8'h00) begin
                        m_cnt   <= m_cnt + 4'h1;
                        m_timer <= half_period(clock_rate) - 8'h01;
                        if (m_cnt == LAST_BIT) begin
                            m_state <= M_IDLE;
                        end else begin
                            m_state <= M_LOW;
                        end
                    end else begin
                        m_timer <= m_timer - 8'h01;
                    end
                end
                default: begin
                    m_state <= M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            m_sample <= 1'b0;
        end else if (m_rise) begin
            m_sample <= si_s2;
        end
    end

    assign m_shift = clock_phase_select ? m_rise : m_fall;
    assign m_din   = clock_phase_select ? si_s2 : m_sample;

    // ************************************************************
    // shift register, mclk side
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            serial_shift_reg <= DATA_RST;
        end else if (bus_wr && word_adr == ADDR_DATA) begin
            serial_shift_reg <= wb_dat_i[7:0];
        end else if (m_shift && cfg_clk_int) begin
            serial_shift_reg <= {serial_shift_reg[6:0], m_din};
        end else if (slave_done) begin
            serial_shift_reg <= s_sr;
        end
    end

    // ************************************************************
    // slave logic on the external shift clock
    // ************************************************************
    // rising edge of link_clk is the shifting edge in both phases
    assign link_clk = clock_phase_select ? shift_clock_in : ~shift_clock_in;

    always_ff @(negedge link_clk) begin
        s_sample <= serial_in;
    end

    assign s_din = clock_phase_select ? serial_in : s_sample;

    // start_tgl and serial_shift_reg are held stable before the frame
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            s_sr       <= DATA_RST;
            s_cnt      <= 4'h0;
            s_seen     <= 1'b0;
            s_done_tgl <= 1'b0;
        end else if (s_seen != start_tgl) begin
            s_sr   <= {serial_shift_reg[6:0], s_din};
            s_cnt  <= 4'h1;
            s_seen <= start_tgl;
        end else if (s_cnt != 4'h0 && s_cnt <= LAST_BIT) begin
            s_sr  <= {s_sr[6:0], s_din};
            s_cnt <= s_cnt + 4'h1;
            if (s_cnt == LAST_BIT) begin
                s_done_tgl <= ~s_done_tgl;
            end
        end
    end

    assign s_frame = s_seen == start_tgl && s_cnt != 4'h0;

    // ************************************************************
    // pins
    // ************************************************************
    always_comb begin
        if (cfg_clk_int) begin
            serial_out = serial_shift_reg[7];
        end else if (s_frame) begin
            serial_out = s_sr[7];
        end else begin
            serial_out = serial_shift_reg[7];
        end
    end

    assign serial_out_oe   = serial_port_select & cfg_out_en;
    assign shift_clock_oe  = serial_port_select & cfg_clk_int;
    assign shift_clock_out = m_state == M_HIGH;

endmodule

//--- rtl/twssp_pkg.sv
package twssp_pkg;

    // ************************************************************
    // register map, word aligned byte addresses
    // ************************************************************
    localparam logic [3:0] ADDR_CONTROL  = 4'h0;
    localparam logic [3:0] ADDR_STATUS   = 4'h4;
    localparam logic [3:0] ADDR_PORT_CFG = 4'h8;
    localparam logic [3:0] ADDR_DATA     = 4'hC;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_RATE_LOW  = 0;
    localparam int CTRL_RATE_HIGH = 1;
    localparam int CTRL_PORT_SEL  = 3;
    localparam int STAT_BUSY      = 0;
    localparam int STAT_IRQ_EN    = 1;
    localparam int CFG_OUT_EN     = 4;
    localparam int CFG_CLK_INT    = 5;
    localparam int CFG_PHASE      = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] RATE_RST = 2'h0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int MCLK_NS       = 40;
    localparam int TC_NS         = 160;
    localparam int TC_MCLK       = TC_NS / MCLK_NS;
    localparam int BYTE_BITS     = 8;
    localparam logic [7:0] HALF_RATE0 = 8'((2 * TC_MCLK) / 2);
    localparam logic [7:0] HALF_RATE1 = 8'((4 * TC_MCLK) / 2);
    localparam logic [7:0] HALF_RATE2 = 8'((8 * TC_MCLK) / 2);
    localparam logic [3:0] LAST_BIT   = 4'(BYTE_BITS - 1);

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LOW  = 2'b01,
        M_HIGH = 2'b10
    } twssp_mstate_t;

endpackage

//--- bench/twssp_checker.sv
`timescale 1ns/1ns
module twssp_checker
    import twssp_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        serial_out,
    input wire logic        serial_out_oe,
    input wire logic        shift_clock_out,
    input wire logic        shift_clock_oe,
    input wire logic        shift_done_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ****************************************
    // shadows of written control bits
    // ****************************************
    logic [7:0] sh_ctrl;
    logic [7:0] sh_cfg;
    logic       sh_ie;
    logic [7:0] hcnt;
    logic [7:0] half;
    logic       wr;
    logic       stat_wr;
    assign wr      = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign stat_wr = wr && (wb_adr_i[3:2] == ADDR_STATUS[3:2]);
    assign half    = sh_ctrl[CTRL_RATE_HIGH] ? HALF_RATE2 :
                     (sh_ctrl[CTRL_RATE_LOW] ? HALF_RATE1 : HALF_RATE0);
    always_ff @(posedge mclk) begin
        if (reset) begin
            sh_ctrl <= 8'h00;
            sh_cfg  <= 8'h00;
            sh_ie   <= 1'b0;
        end else if (wr) begin
            case (wb_adr_i[3:2])
                ADDR_CONTROL[3:2]:  sh_ctrl <= wb_dat_i[7:0];
                ADDR_STATUS[3:2]:   sh_ie <= wb_dat_i[STAT_IRQ_EN];
                ADDR_PORT_CFG[3:2]: sh_cfg <= wb_dat_i[7:0];
                default:            sh_ie <= sh_ie;
            endcase
        end
    end
    // consecutive mclk cycles with shift_clock_out high
    always_ff @(posedge mclk) begin
        if (reset) begin
            hcnt <= 8'h00;
        end else begin
            hcnt <= shift_clock_out ? hcnt + 8'h01 : 8'h00;
        end
    end
    chk_ack_wait: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_out_enable: assert property (
        serial_out_oe == (sh_ctrl[CTRL_PORT_SEL] && sh_cfg[CFG_OUT_EN]))
        else $error("data pin enable wrong");
    chk_clock_enable: assert property (
        shift_clock_oe == (sh_ctrl[CTRL_PORT_SEL] && sh_cfg[CFG_CLK_INT]))
        else $error("clock pin enable wrong");
    chk_clock_idle: assert property (!shift_clock_oe |-> !shift_clock_out)
        else $error("clock runs without master mode");
    chk_half_period: assert property (
        ($fell(shift_clock_out) && !$past(stat_wr)) |-> hcnt == half)
        else $error("clock high time wrong for rate");
    chk_abort_stop: assert property (
        (stat_wr && !wb_dat_i[STAT_BUSY]) |=> !shift_clock_out [*8])
        else $error("clock still runs after abort");
    chk_irq_enable: assert property (shift_done_irq |-> sh_ie)
        else $error("irq while disabled");
    chk_irq_pulse: assert property (shift_done_irq |=> !shift_done_irq)
        else $error("irq longer than one cycle");
    chk_out_edge: assert property (
        ($changed(serial_out) && !$past(wr) && sh_ctrl[CTRL_PORT_SEL] && sh_cfg[CFG_CLK_INT])
        |-> (sh_cfg[CFG_PHASE] ? $rose(shift_clock_out) : $fell(shift_clock_out)))
        else $error("data out changed on wrong clock edge");
endmodule
bind twssp_top twssp_checker chk (
    .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .shift_clock_out(shift_clock_out), .shift_clock_oe(shift_clock_oe),
    .shift_done_irq(shift_done_irq)
);

//--- bench/twssp_partner.sv
`timescale 1ns/1ns
module twssp_partner (
    input  wire logic       dut_sck,
    input  wire logic       dut_sck_oe,
    input  wire logic       dut_so,
    input  wire logic       dut_so_oe,
    input  wire logic       alt,
    output logic            so,
    output logic            sck_ext,
    output logic [7:0]      rx
);
    logic [7:0] tx;
    wire logic  sck;
    wire logic  din;
    // an undriven data pin reads as the inverse of dut_so, not as its last level
    assign din = dut_so_oe ? dut_so : ~dut_so;
    // follow whichever side owns the clock
    assign sck = dut_sck_oe ? dut_sck : sck_ext;
    assign so  = tx[7];
    initial begin
        tx      = 8'h00;
        rx      = 8'h00;
        sck_ext = 1'b0;
    end
    // sample on the edge opposite the one the port shifts on
    always @(posedge sck) if (!alt) rx <= {rx[6:0], din};
    always @(negedge sck) if (alt) rx <= {rx[6:0], din};
    always @(negedge sck) tx <= {tx[6:0], ~tx[0]};
    task automatic load(input logic [7:0] t);
        tx = t;
    endtask
    // one byte as master, clock low outside frames
    task automatic frame();
        #7;
        repeat (8) begin
            #15 sck_ext = 1'b1;
            #15 sck_ext = 1'b0;
        end
    endtask
endmodule

//--- bench/test_twssp_top.sv
`timescale 1ns/1ns
module test_twssp_top;
    import twssp_pkg::*;
    logic        mclk;
    logic        reset;
    logic        wb_cyc;
    logic        wb_we;
    logic [3:0]  wb_adr;
    logic [31:0] wb_dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack;
    logic        serial_in;
    logic        serial_out;
    logic        so_oe;
    logic        sck_in;
    logic        sck_out;
    logic        sck_oe;
    logic        irq;
    logic [7:0]  rx;
    logic        rd_note;
    logic        alt_mode;
    logic [31:0] exp_q[$];
    int          num_errors;
    int          samples_checked;
    int          irq_cnt;
    int          exp_irq;
    int          seed;
    twssp_top dut (
        .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(so_oe), .shift_clock_in(sck_in),
        .shift_clock_out(sck_out), .shift_clock_oe(sck_oe), .shift_done_irq(irq)
    );
    twssp_partner partner (
        .dut_sck(sck_out), .dut_sck_oe(sck_oe), .dut_so(serial_out), .dut_so_oe(so_oe),
        .alt(alt_mode), .so(serial_in), .sck_ext(sck_in), .rx(rx)
    );
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************
    // bus cycles
    // ****************************************
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                       input logic note, output logic [31:0] q);
        @(posedge mclk);
        wb_cyc  <= 1'b1;
        rd_note <= note;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge mclk); while (wb_ack !== 1'b1);
        q = wb_dat_o;
        wb_cyc  <= 1'b0;
        rd_note <= 1'b0;
        wb_we   <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, 1'b0, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0, 1'b1, q);
    endtask
    task automatic wait_idle();
        logic [31:0] q;
        int          n;
        n = 0;
        q = 32'h1;
        while (q[STAT_BUSY] !== 1'b0 && n < 400) begin
            bus(ADDR_STATUS, 1'b0, 32'h0, 1'b0, q);
            n++;
        end
    endtask
    task automatic xfer(input logic ie, input logic alt, input logic slv);
        logic [7:0] d;
        logic [7:0] t;
        d = 8'($random(seed));
        t = 8'($random(seed));
        alt_mode <= alt;
        partner.load(t);
        wr(ADDR_DATA, {24'h0, d});
        wr(ADDR_STATUS, {30'h0, ie, 1'b1});
        if (slv) begin
            repeat (4) @(posedge mclk);
            partner.frame();
        end
        wait_idle();
        if (ie) exp_irq++;
        rd(ADDR_STATUS, {30'h0, ie, 1'b0});
        rd(ADDR_DATA, {24'h0, t});
        check("peer_rx", {24'h0, rx}, alt ? {24'h0, d[6:0], t[7]} : {24'h0, d});
        check("irq_count", 32'(irq_cnt), 32'(exp_irq));
    endtask
    // read results against the oldest note
    always @(posedge mclk) begin
        if (wb_ack === 1'b1 && rd_note === 1'b1) begin
            check("rdata", wb_dat_o, exp_q.pop_front());
        end
    end
    always @(posedge mclk) begin
        if (irq === 1'b1) irq_cnt++;
    end
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        stop_test();
    end
    initial begin
        reset = 1'b1;
        wb_cyc = 1'b0;
        wb_we = 1'b0;
        wb_adr = 4'h0;
        wb_dat = 32'h0;
        rd_note = 1'b0;
        alt_mode = 1'b0;
        seed = 32'ha2ad;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
        wr(ADDR_PORT_CFG, 32'h30);
        wr(ADDR_STATUS, 32'h1);
        rd(ADDR_STATUS, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CONTROL, 32'(8 + (i % 4)));
            wr(ADDR_PORT_CFG, (i == 4) ? 32'h70 : 32'h30);
            xfer(1'(i), 1'(i == 4), 1'b0);
        end
        wr(ADDR_CONTROL, 32'h0B);
        wr(ADDR_PORT_CFG, 32'h30);
        wr(ADDR_STATUS, 32'h3);
        repeat (40) @(posedge mclk);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h2);
        repeat (300) @(posedge mclk);
        rd(ADDR_STATUS, 32'h2);
        check("irq_count", 32'(irq_cnt), 32'(exp_irq));
        wr(ADDR_PORT_CFG, 32'h10);
        xfer(1'b1, 1'b0, 1'b1);
        stop_test();
    end
endmodule
